// *** rtl/asr_host_ctrl.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Host keeps each read address stable for at least one read cycle time.
// - Host holds select low one read cycle; address valid by select fall.
// - Host keeps the write strobe high throughout every read cycle.
// - Address changes only while select or write strobe is high.
// - Write strobe pulse lasts at least 20 or 25 ns within a write cycle.
// - Select and address precede the strobe rise by at least a write cycle.
// - Address is stable at least 5 or 10 ns before strobe falls.
// - Write data is valid 15 or 20 ns before strobe rises.
// - Address hold counts from whichever of select or strobe rises first.
// - In a select-ended write, strobe is low 20 or 25 ns before select rises.
// - In a select-ended write, data holds 5 ns after select rises.
module asr_host_ctrl
    import asr_pkg::*;
#(
    parameter int SPEED_GRADE = 0
) (
    input  wire logic     clk_sys,
    input  wire logic     rst_n,
    input  wire logic     reqValid,
    input  wire asr_req_t reqCmd,
    output logic          reqReady,
    output logic          rspValid,
    output logic          rspData,
    output asr_pins_t     devPins,
    input  wire logic     devQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts for the chosen grade
    localparam int CYC_ACC  = asr_cyc_up(T_ACC_NS[SPEED_GRADE]);
    localparam int CYC_RC   = asr_cyc_up(T_RC_NS[SPEED_GRADE]);
    localparam int CYC_HZ   = asr_cyc_up(T_HZ_NS[SPEED_GRADE]);
    localparam int CYC_WC   = asr_cyc_up(T_WC_NS[SPEED_GRADE]);
    localparam int CYC_WP   = asr_cyc_up(T_WP_NS[SPEED_GRADE]);
    localparam int CYC_EW   = asr_cyc_up(T_EW_NS[SPEED_GRADE]);
    localparam int CYC_AS   = asr_cyc_up(T_AS_NS[SPEED_GRADE]);
    localparam int CYC_DW   = asr_cyc_up(T_DW_NS[SPEED_GRADE]);
    localparam int CYC_DH   = asr_cyc_up(T_DH_NS[SPEED_GRADE]);
    // Read waits for access plus the pin synchroniser, never less than a read cycle
    localparam int CYC_RD   = (CYC_ACC + SYNC_STAGES > CYC_RC) ? CYC_ACC + SYNC_STAGES : CYC_RC;
    localparam int CYC_PW0  = (CYC_WP > CYC_DW) ? CYC_WP : CYC_DW;
    localparam int CYC_PW   = (CYC_PW0 > CYC_EW - CYC_AS) ? CYC_PW0 : CYC_EW - CYC_AS;
    localparam int CYC_WR_R = (CYC_DH > CYC_WC - CYC_AS - CYC_PW) ? CYC_DH : CYC_WC - CYC_AS - CYC_PW;

    localparam logic [TIMER_W-1:0] LD_RD    = TIMER_W'(CYC_RD - 1);
    localparam logic [TIMER_W-1:0] LD_RD_R  = TIMER_W'(CYC_HZ - 1);
    localparam logic [TIMER_W-1:0] LD_AS    = TIMER_W'(CYC_AS - 1);
    localparam logic [TIMER_W-1:0] LD_PW    = TIMER_W'(CYC_PW - 1);
    localparam logic [TIMER_W-1:0] LD_WR_R  = TIMER_W'(CYC_WR_R - 1);
    localparam logic [AGE_W-1:0]   AGE_MAX  = '1;
    localparam logic [AGE_W-1:0]   AGE_ONE  = AGE_W'(1);

    if (SPEED_GRADE < 0 || SPEED_GRADE >= NUM_GRADES) begin : g_bad_grade
        $error("asr_host_ctrl: unknown speed grade");
    end
    if (CYC_RD >= (1 << TIMER_W) || CYC_PW >= (1 << TIMER_W)) begin : g_bad_timer
        $error("asr_host_ctrl: timer too narrow for the chosen clock");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    asr_state_t           stateReg,    stateNext;
    logic [TIMER_W-1:0]   timerReg,    timerNext;
    asr_pins_t            pinsReg,     pinsNext;
    logic                 readyReg,    readyNext;
    logic                 rspValidReg, rspValidNext;
    logic                 rspDataReg,  rspDataNext;
    logic                 qSync;
    logic                 timerDone;
    logic                 accept;

    // Device output is asynchronous to us; two flops before anything reads it
    asr_pin_sync #(
        .WIDTH  (1),
        .STAGES (SYNC_STAGES)
    ) u_q_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .pinAsync (devQ),
        .pinSync  (qSync)
    );

    // Decodes
    assign timerDone = (timerReg == '0);
    assign accept    = reqValid && readyReg;
    assign readyNext = (stateNext == ASR_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: every pin moves on a clock edge, so pin-to-pin times are whole cycles
    always_comb begin
        stateNext    = stateReg;
        timerNext    = timerDone ? timerReg : timerReg - TIMER_W'(1);
        pinsNext     = pinsReg;
        rspValidNext = 1'b0;
        rspDataNext  = rspDataReg;
        case (stateReg)
            ASR_IDLE: begin
                if (accept) begin
                    // Address and select move together: zero setup is allowed
                    pinsNext.wordSelectLines = reqCmd.addr;
                    pinsNext.selN            = 1'b0;
                    pinsNext.wrN             = 1'b1;   // Strobe high while address moves
                    if (reqCmd.write) begin
                        pinsNext.dIn = reqCmd.data;    // Data set up with the address
                        timerNext    = LD_AS;          // Address setup before strobe
                        stateNext    = ASR_WR_SETUP;
                    end else begin
                        timerNext = LD_RD;             // Access plus sync, at least a read cycle
                        stateNext = ASR_RD_ACCESS;
                    end
                end
            end
            ASR_RD_ACCESS: begin
                if (timerDone) begin
                    rspDataNext  = qSync;              // Sampled after access time
                    rspValidNext = 1'b1;
                    pinsNext.selN = 1'b1;              // Select held a full read cycle
                    timerNext    = LD_RD_R;            // Let the output float off
                    stateNext    = ASR_RECOVER;
                end
            end
            ASR_WR_SETUP: begin
                if (timerDone) begin
                    pinsNext.wrN = 1'b0;               // Store while both are low
                    timerNext    = LD_PW;              // Pulse width and select time
                    stateNext    = ASR_WR_PULSE;
                end
            end
            ASR_WR_PULSE: begin
                if (timerDone) begin
                    // Both rise on one edge; address and data hold past it
                    pinsNext.selN = 1'b1;
                    pinsNext.wrN  = 1'b1;
                    rspValidNext  = 1'b1;
                    timerNext     = LD_WR_R;           // Data hold and rest of write cycle
                    stateNext     = ASR_RECOVER;
                end
            end
            ASR_RECOVER: begin
                if (timerDone) begin
                    stateNext = ASR_IDLE;
                end
            end
            default: begin
                stateNext = ASR_IDLE;
            end
        endcase
    end

    // State and pin registers; idle pins leave the device in standby
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stateReg    <= ASR_IDLE;
            timerReg    <= '0;
            pinsReg     <= '{wordSelectLines: '0, selN: 1'b1, wrN: 1'b1, dIn: 1'b0};
            readyReg    <= 1'b1;
            rspValidReg <= 1'b0;
            rspDataReg  <= 1'b0;
        end else begin
            stateReg    <= stateNext;
            timerReg    <= timerNext;
            pinsReg     <= pinsNext;
            readyReg    <= readyNext;
            rspValidReg <= rspValidNext;
            rspDataReg  <= rspDataNext;
        end
    end

    assign devPins  = pinsReg;
    assign reqReady = readyReg;
    assign rspValid = rspValidReg;
    assign rspData  = rspDataReg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin age counters: cycles each pin value has stood, used only by the checks
    logic [AGE_W-1:0] addrAge;
    logic [AGE_W-1:0] dataAge;
    logic [AGE_W-1:0] selLowAge;
    logic [AGE_W-1:0] wrLowAge;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addrAge   <= '0;
            dataAge   <= '0;
            selLowAge <= '0;
            wrLowAge  <= '0;
        end else begin
            addrAge   <= (pinsNext.wordSelectLines != pinsReg.wordSelectLines) ? AGE_ONE :
                         (addrAge == AGE_MAX) ? addrAge : addrAge + AGE_ONE;
            dataAge   <= (pinsNext.dIn != pinsReg.dIn) ? AGE_ONE :
                         (dataAge == AGE_MAX) ? dataAge : dataAge + AGE_ONE;
            selLowAge <= pinsNext.selN ? '0 : (selLowAge == AGE_MAX) ? selLowAge : selLowAge + AGE_ONE;
            wrLowAge  <= pinsNext.wrN ? '0 : (wrLowAge == AGE_MAX) ? wrLowAge : wrLowAge + AGE_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the pins we drive
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_read_addr_hold: assert property (
        ($rose(pinsReg.selN) && $past(pinsReg.wrN)) |-> ($past(addrAge) >= CYC_RC)
    ) else $error("read address changed before a read cycle elapsed");

    a_read_sel_len: assert property (
        ($rose(pinsReg.selN) && $past(pinsReg.wrN)) |-> ($past(selLowAge) >= CYC_RD)
    ) else $error("read select shorter than the read hold");

    a_read_wr_high: assert property (
        (stateReg == ASR_RD_ACCESS) |-> (pinsReg.wrN throughout (stateReg == ASR_RD_ACCESS)[*1])
    ) else $error("write strobe low during a read");

    a_addr_move_safe: assert property (
        $changed(pinsReg.wordSelectLines) |-> (($past(pinsReg.selN) || $past(pinsReg.wrN)) && pinsReg.wrN)
    ) else $error("address moved during an active write");

    a_wr_pulse_width: assert property (
        $rose(pinsReg.wrN) |-> ($past(wrLowAge) >= CYC_WP) && ($past(wrLowAge) >= CYC_PW)
    ) else $error("write strobe pulse too short");

    a_sel_to_wr_end: assert property (
        $rose(pinsReg.wrN) |-> ($past(selLowAge) >= CYC_EW) && ($past(addrAge) >= CYC_EW)
    ) else $error("select or address too late before write end");

    a_addr_setup_wr: assert property (
        $fell(pinsReg.wrN) |-> ($past(addrAge) >= CYC_AS) && !pinsReg.selN
    ) else $error("address setup before strobe fall too short");

    a_data_setup_wr: assert property (
        $rose(pinsReg.wrN) |-> ($past(dataAge) >= CYC_DW)
    ) else $error("write data setup too short");

    a_addr_hold_end: assert property (
        ($rose(pinsReg.selN) && !$past(pinsReg.wrN)) |-> $stable(pinsReg.wordSelectLines) ##1
            $stable(pinsReg.wordSelectLines)
    ) else $error("address moved at the end of a write");

    a_sel_write_end: assert property (
        ($rose(pinsReg.selN) && !$past(pinsReg.wrN)) |-> ($past(wrLowAge) >= CYC_WP) &&
            $stable(pinsReg.dIn) ##1 $stable(pinsReg.dIn)
    ) else $error("select-ended write strobe or data hold too short");

    a_write_ack_time: assert property (
        (accept && reqCmd.write) |-> ##(1) (!rspValid)[*1] ##0 (stateReg == ASR_WR_SETUP)
    ) else $error("write did not start its setup phase");

endmodule : asr_host_ctrl

// *** rtl/asr_pin_sync.sv ***
`timescale 1ns/1ns
module asr_pin_sync
    import asr_pkg::*;
#(
    parameter int WIDTH  = 1,
    parameter int STAGES = SYNC_STAGES
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinAsync,
    output logic      [WIDTH-1:0] pinSync
);

    ////////////////////////////////////////////////////////////////////////////
    // Fewer than two stages would let a metastable level reach the logic
    if (STAGES < 2) begin : g_bad_stages
        $error("asr_pin_sync needs at least two stages");
    end

    logic [WIDTH-1:0] stageReg [STAGES];

    // Plain shift chain; only the next stage reads each stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                stageReg[i] <= '0;
            end
        end else begin
            stageReg[0] <= pinAsync;
            for (int i = 1; i < STAGES; i++) begin
                stageReg[i] <= stageReg[i-1];
            end
        end
    end

    assign pinSync = stageReg[STAGES-1];

endmodule : asr_pin_sync

// *** rtl/asr_pkg.sv ***
package asr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry and clock
    localparam int ADDR_W        = 14;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NUM_GRADES    = 3;
    localparam int SYNC_STAGES   = 2;
    localparam int TIMER_W       = 8;
    localparam int AGE_W         = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Device timing per speed grade, in ns (index 0 is the fastest grade)
    localparam int T_ACC_NS [NUM_GRADES] = '{35, 45, 55};   // Address or select to data valid, max
    localparam int T_RC_NS  [NUM_GRADES] = '{35, 45, 55};   // Read cycle, min
    localparam int T_HZ_NS  [NUM_GRADES] = '{25, 25, 30};   // Select high to output released, max
    localparam int T_WC_NS  [NUM_GRADES] = '{35, 45, 55};   // Write cycle, min
    localparam int T_WP_NS  [NUM_GRADES] = '{20, 20, 25};   // Write strobe low, min
    localparam int T_EW_NS  [NUM_GRADES] = '{35, 45, 55};   // Select low to end of write, min
    localparam int T_AS_NS  [NUM_GRADES] = '{5, 5, 10};     // Address setup to strobe fall, min
    localparam int T_DW_NS  [NUM_GRADES] = '{15, 15, 20};   // Data setup to end of write, min
    localparam int T_DH_NS  [NUM_GRADES] = '{5, 5, 5};      // Data hold after select rises, min

    ////////////////////////////////////////////////////////////////////////////
    // Carriers and states
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic              data;
    } asr_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] wordSelectLines;
        logic              selN;
        logic              wrN;
        logic              dIn;
    } asr_pins_t;

    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_RD_ACCESS,
        ASR_WR_SETUP,
        ASR_WR_PULSE,
        ASR_RECOVER
    } asr_state_t;

    // Least time to whole clock cycles, rounded up, never below one
    function automatic int asr_cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : asr_cyc_up

endpackage : asr_pkg

// *** tb/asr_host_ctrl_tb.sv ***
`timescale 1ns/1ns
module asr_host_ctrl_tb
    import asr_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////
    localparam int GR = 0;
    localparam int AS = (T_AS_NS[GR] + 9) / 10;
    localparam int WP = (T_WP_NS[GR] + 9) / 10;
    localparam int EW = (T_EW_NS[GR] + 9) / 10;
    localparam int DW = (T_DW_NS[GR] + 9) / 10;
    localparam int RC = (T_RC_NS[GR] + 9) / 10;
    localparam logic [ADDR_W-1:0] ADDRS [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};

    logic        clk_sys;
    logic        rst_n;
    logic        reqValid;
    logic        reqReady;
    logic        rspValid;
    logic        rspData;
    logic        devQ;
    logic [31:0] accNs;
    asr_req_t    reqCmd;
    asr_pins_t   devPins;
    asr_pins_t   prevP;
    int          bad_count;
    int          n_compared;
    int          aAge;
    int          dAge;
    int          wLow;
    int          sLow;
    int          wrFalls;

    asr_host_ctrl #(.SPEED_GRADE(GR)) uut (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .reqValid(reqValid),
        .reqCmd  (reqCmd),
        .reqReady(reqReady),
        .rspValid(rspValid),
        .rspData (rspData),
        .devPins (devPins),
        .devQ    (devQ)
    );

    asr_sram_model mem_model (
        .pins (devPins),
        .accNs(accNs),
        .q    (devQ)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////
    // Pin watcher: counts in whole cycles, so it is only as fine as the clock
    always @(negedge clk_sys) begin
        if (rst_n) begin
            if (devPins.wordSelectLines !== prevP.wordSelectLines) begin
                chk((prevP.wrN | prevP.selN) & (devPins.wrN | devPins.selN), 1);
                aAge = -1;
            end
            if (devPins.dIn !== prevP.dIn)
                dAge = -1;
            if (prevP.wrN === 1'b1 && devPins.wrN === 1'b0) begin
                wrFalls++;
                chk(aAge + 1 >= AS, 1);
            end
            if (prevP.wrN === 1'b0 && devPins.wrN === 1'b1) begin
                chk(wLow >= WP && sLow >= EW, 1);
                chk(aAge + 1 >= EW && dAge + 1 >= DW, 1);
            end
            if (prevP.selN === 1'b0 && devPins.selN === 1'b1) begin
                chk(devPins.wordSelectLines === prevP.wordSelectLines && dAge >= 0, 1);
                if (prevP.wrN === 1'b1)
                    chk(sLow >= RC, 1);
            end
            wLow = devPins.wrN ? 0 : wLow + 1;
            sLow = devPins.selN ? 0 : sLow + 1;
            aAge++;
            dAge++;
        end else begin
            aAge = 0;
            dAge = 0;
            wLow = 0;
            sLow = 0;
        end
        prevP = devPins;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One request, entered and left at a falling edge; next one may follow at once
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic d);
        int n;
        int lat;
        int falls;
        int hits;
        hits = 0;
        reqValid = 1'b1;
        reqCmd = '{write: wr, addr: a, data: d};
        n = 0;
        while (reqReady !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        falls = wrFalls;
        @(negedge clk_sys);
        reqValid = 1'b0;
        lat = -1;
        n = 0;
        while (reqReady !== 1'b1 && n < 30) begin
            if (rspValid === 1'b1) begin
                lat = n;
                hits++;
            end
            @(negedge clk_sys);
            n++;
        end
        chk(lat, wr ? 4 : 6);
        chk(hits, 1);
        chk(n, wr ? 5 : 9);
        if (wr) begin
            chk(wrFalls, falls + 1);
        end else begin
            chk(rspData, d);
            chk(wrFalls, falls);
        end
    endtask : xfer

    // Corner addresses, both bit values, requests back to back with a prompt device
    task automatic t_table();
        accNs = 32'd10;
        for (int i = 0; i < 4; i++)
            xfer(1'b1, ADDRS[i], i[0]);
        for (int i = 3; i >= 0; i--)
            xfer(1'b0, ADDRS[i], i[0]);
    endtask : t_table

    // Device answering at its latest allowed time; overwrite and read across neighbours
    task automatic t_slow();
        accNs = T_ACC_NS[GR];
        xfer(1'b1, 14'h3FFF, 1'b0);
        xfer(1'b1, 14'h0000, 1'b1);
        xfer(1'b0, 14'h3FFF, 1'b0);
        xfer(1'b0, 14'h0000, 1'b1);
        xfer(1'b0, 14'h1555, 1'b0);
        xfer(1'b0, 14'h1555, 1'b0);
    endtask : t_slow

    // Reset dropped inside a write pulse; pins fall back to idle and the next read is clean
    task automatic t_reset();
        reqValid = 1'b1;
        reqCmd = '{write: 1'b1, addr: 14'h2AAA, data: 1'b0};
        @(negedge clk_sys);
        reqValid = 1'b0;
        @(negedge clk_sys);
        chk(devPins.wrN, 1'b0);
        rst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({reqReady, rspValid, rspData}, 3'h4);
        chk(devPins, 17'h00006);
        rst_n = 1'b1;
        xfer(1'b0, 14'h0000, 1'b1);
    endtask : t_reset

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqCmd = '0;
        accNs = 32'd10;
        bad_count = 0;
        n_compared = 0;
        wrFalls = 0;
        repeat (4) @(negedge clk_sys);
        chk({reqReady, rspValid, rspData}, 3'h4);
        chk(devPins, 17'h00006);
        rst_n = 1'b1;
        t_table();
        t_slow();
        t_reset();
        tally_and_finish();
    end

    // Whole run needs some 140 cycles; this is far beyond it
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule : asr_host_ctrl_tb

// *** tb/asr_sram_model.sv ***
`timescale 1ns/1ns
module asr_sram_model
    import asr_pkg::*;
(
    input  wire asr_pins_t   pins,
    input  wire logic [31:0] accNs,
    output logic             q
);
    ////////////////////////////////////////////////////////////////////////////
    logic mem [0:(1<<ADDR_W)-1];   // One bit per word
    logic drvNow;
    logic drvLate;
    logic qData;
    logic qFloat;

    // Drives when selected and not writing; always awake while selected
    assign drvNow = !pins.selN && pins.wrN;
    // Turn-on and release lag the pins, well inside the limits
    assign #5 drvLate = drvNow;

    // Store while both strobes are low, same polarity as written
    always @(pins) begin
        if (!pins.selN && !pins.wrN)
            mem[pins.wordSelectLines] = pins.dIn;
    end

    // Old data holds 3 ns, then garbage until the access time runs out
    always @(pins.wordSelectLines or drvNow) begin
        qData <= #3 ~qData;
        qData <= #(accNs) mem[pins.wordSelectLines];
    end

    // Released output has no pull: show a toggling level, never the last bit
    initial begin
        qFloat = 1'b0;
        forever #7 qFloat = ~qFloat;
    end

    assign q = drvLate ? qData : qFloat;
endmodule : asr_sram_model
